// ### rtl/dph_pkg.sv
// Constants, descriptor layout and channel configuration for the DMA hub.
// Assumes a single 250 MHz clock domain shared by every user of the package.
package dph_pkg;

  // ****************************************************************
  // Sizes and encodings
  // ****************************************************************
  localparam int NCH = 24;
  localparam int NTD = 127;
  localparam logic [6:0] TD_END = 7'h7f;
  localparam int SPOKE_LSB = 16;
  localparam int SPOKE_W = 3;
  localparam int DESC_LSB = 11;
  localparam logic [20:0] DESC_TAG = 21'h000040;
  localparam logic [7:0] STARVE_LIM = 8'h10;
  localparam logic [1:0] QDEPTH = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  // One transfer_descriptor, 16 bytes in the descriptor pool
  typedef struct packed {
    logic [34:0] rsvd;
    logic auto_next;
    logic irq1;
    logic irq0;
    logic dst_inc;
    logic src_inc;
    logic infinite;
    logic [6:0] next_td;
    logic [15:0] len_m1;
    logic [31:0] dst;
    logic [31:0] src;
  } dph_td_t;

  // Per-channel static configuration
  typedef struct packed {
    logic en;
    logic [2:0] prio;
    logic rr_dis;
    logic [6:0] burst;
    logic [4:0] chain_src;
    logic [6:0] first_td;
  } dph_ch_cfg_t;

  typedef enum logic [1:0] {
    ST_ARB = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b10
  } dph_state_t;

endpackage

// ### rtl/dph_hub.sv
// DMA controller with spoke arbitration and a memory-mapped descriptor pool.
// Assumes spoke slaves answer rd_req/wr_req with a one-cycle ack, and that
// the CPU master holds cpu_req until cpu_gnt.
// Functional notes
// - Twenty-four channels share a pool of up to 127 descriptors.
// - Priority 0 is highest of eight; higher pending channels preempt lower ones.
// - A preempted channel finishes its current burst before the switch.
// - Routed triggers, CPU triggers or another channel's completion start a channel.
// - Each descriptor may pulse term0 per transfer; term1 pulses only for the descriptor that ends the chain.
// - Channels can be stalled or cancelled on request.
// - Lengths run 1 to 64k bytes, or endlessly when infinite is set.
// - Transfers split into bursts of 1 to 127 bytes, re-arbitrating between.
// - Each descriptor names a next one, forming chains and nested sequences.
// - CPU wins a shared spoke, but a starvation counter forces DMA turns.
// - Fairness slots give levels 2 to 7 halving shares of bandwidth.
// - Levels 0 and 1 bypass fairness and are served first.
// - Equal-priority channels rotate grants round robin.
// - Channels with round robin disabled win ties at their level, the lowest-numbered first.
// - Without fairness, grants follow priority level only.
// - Eight spokes, taken from address bits; spoke 0 is SRAM.
// - CPU and DMA proceed together when their spokes differ.
// - Source read and destination write overlap on different spokes.
// - A descriptor linked to itself repeats forever.
// - Two linked descriptors alternate; longer rings cycle through buffers.
// - A transfer can write a fetched address into a later descriptor.
// - Descriptor pool is writable by CPU and DMA, even while active.
`timescale 1ns/100ps
module dph_hub (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Channel control
  input dph_pkg::dph_ch_cfg_t chan_cfg [dph_pkg::NCH],
  input wire logic fair_en,
  input wire logic [dph_pkg::NCH-1:0] trig_in,
  input wire logic [dph_pkg::NCH-1:0] cpu_trig,
  input wire logic [dph_pkg::NCH-1:0] stall_req,
  input wire logic [dph_pkg::NCH-1:0] cancel_req,
  // CPU descriptor pool write port
  input wire logic cfg_wr,
  input wire logic [10:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  // CPU master on the spokes
  input wire logic cpu_req,
  input wire logic [dph_pkg::SPOKE_W-1:0] cpu_spoke,
  output logic cpu_gnt,
  // DMA source read port
  output logic rd_req,
  output logic [31:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data,
  // DMA destination write port
  output logic wr_req,
  output logic [31:0] wr_addr,
  output logic [7:0] wr_data,
  input wire logic wr_ack,
  // Completion and status
  output logic [dph_pkg::NCH-1:0] term0,
  output logic [dph_pkg::NCH-1:0] term1,
  output logic busy,
  output logic [4:0] act_ch
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Spoke number of an address
  function automatic logic [2:0] spk(input logic [31:0] a);
    return a[dph_pkg::SPOKE_LSB +: dph_pkg::SPOKE_W];
  endfunction

  // Address falls inside the descriptor pool window
  function automatic logic is_desc(input logic [31:0] a);
    return a[31:dph_pkg::DESC_LSB] == dph_pkg::DESC_TAG;
  endfunction

  // Winning priority level
  function automatic logic [2:0] pick_lvl(input logic [7:0] lr, input logic fair,
                                          input logic [6:0] slot);
    logic [2:0] lo;
    logic [2:0] fav;
    lo = 3'h0;
    fav = 3'h7;
    for (int i = 7; i >= 0; i--) begin
      if (lr[i]) begin
        lo = 3'(i);
      end
    end
    // Lowest set slot bit picks the favoured level
    for (int i = 4; i >= 0; i--) begin
      if (slot[i]) begin
        fav = 3'(i + 2);
      end
    end
    if (fair && !lr[0] && !lr[1] && lr[fav]) begin
      return fav;
    end
    return lo;
  endfunction

  // Winning channel within one level
  function automatic logic [4:0] pick_ch(input logic [23:0] m, input logic [23:0] dis,
                                         input logic [4:0] last);
    logic [4:0] r;
    logic hit;
    int j;
    r = 5'h00;
    hit = 1'b0;
    j = 0;
    for (int i = 23; i >= 0; i--) begin
      if (m[i] && dis[i]) begin
        r = 5'(i);
        hit = 1'b1;
      end
    end
    if (!hit) begin
      for (int i = 24; i >= 1; i--) begin
        j = (int'(last) + i) % 24;
        if (m[j]) begin
          r = 5'(j);
        end
      end
    end
    return r;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  dph_pkg::dph_td_t pool [dph_pkg::NTD];
  dph_pkg::dph_state_t st_ff, nxt_st;
  logic [4:0] ch_ff, nxt_ch;
  dph_pkg::dph_td_t td_ff, nxt_td;
  logic [31:0] src_ff, nxt_src;
  logic [31:0] dst_ff, nxt_dst;
  logic [16:0] rcnt_ff, nxt_rcnt;
  logic [15:0] wcnt_ff, nxt_wcnt;
  logic [6:0] brd_ff, nxt_brd;
  logic [6:0] bwr_ff, nxt_bwr;
  logic [1:0] bcnt_ff, nxt_bcnt;
  logic [7:0] bq0_ff, nxt_bq0;
  logic [7:0] bq1_ff, nxt_bq1;
  logic [7:0] starve_ff, nxt_starve;
  logic [6:0] slot_ff, nxt_slot;
  logic [4:0] rrp_ff, nxt_rrp;
  logic [23:0] pend_ff, nxt_pend;
  logic [6:0] ctd_ff [dph_pkg::NCH];
  logic [6:0] nxt_ctd [dph_pkg::NCH];
  logic [15:0] cwc_ff [dph_pkg::NCH];
  logic [15:0] nxt_cwc [dph_pkg::NCH];
  logic [23:0] term0_ff, nxt_term0;
  logic [23:0] term1_ff, nxt_term1;

  dph_pkg::dph_ch_cfg_t cur;
  logic rd_want, wr_want, wr_bus, dwr, hit_r, hit_w, dma_first;
  logic rd_fire, wr_fire, last_w, abort;
  logic [1:0] qn;
  logic [23:0] req, lvl_m, dis_m, clr, set;
  logic [7:0] lr;
  logic [2:0] lvl;
  logic [4:0] sel;

  // ****************************************************************
  // Spoke access and CPU precedence
  // ****************************************************************
  // Reads pipeline ahead of writes only on differing spokes
  always_comb begin
    cur = chan_cfg[ch_ff];
    abort = cancel_req[ch_ff] || !cur.en;
    rd_want = (st_ff == dph_pkg::ST_RUN) && !abort && !stall_req[ch_ff] &&
              (brd_ff < cur.burst) && (bcnt_ff < dph_pkg::QDEPTH) &&
              (td_ff.infinite || rcnt_ff <= {1'b0, td_ff.len_m1}) &&
              (bcnt_ff == 2'h0 || spk(src_ff) != spk(dst_ff));
    wr_want = (st_ff == dph_pkg::ST_RUN) && !abort && (bcnt_ff != 2'h0);
    dwr = wr_want && is_desc(dst_ff) && !cfg_wr;
    wr_bus = wr_want && !is_desc(dst_ff);
    hit_r = cpu_req && cpu_spoke == spk(src_ff);
    hit_w = cpu_req && cpu_spoke == spk(dst_ff);
    dma_first = starve_ff >= dph_pkg::STARVE_LIM;
    rd_req = rd_want && (!hit_r || dma_first);
    wr_req = wr_bus && (!hit_w || dma_first);
    cpu_gnt = cpu_req && !(dma_first && ((rd_want && hit_r) || (wr_bus && hit_w)));
    rd_fire = rd_req && rd_ack;
    wr_fire = (wr_req && wr_ack) || dwr;
    last_w = wr_fire && !td_ff.infinite && (wcnt_ff == td_ff.len_m1);
  end

  // ****************************************************************
  // Arbitration request vectors
  // ****************************************************************
  always_comb begin
    lr = 8'h00;
    lvl_m = 24'h000000;
    dis_m = 24'h000000;
    for (int k = 0; k < dph_pkg::NCH; k++) begin
      req[k] = pend_ff[k] && chan_cfg[k].en && !stall_req[k] && !cancel_req[k];
      if (req[k]) begin
        lr[chan_cfg[k].prio] = 1'b1;
      end
    end
    lvl = pick_lvl(lr, fair_en, slot_ff);
    for (int k = 0; k < dph_pkg::NCH; k++) begin
      lvl_m[k] = req[k] && (chan_cfg[k].prio == lvl);
      dis_m[k] = chan_cfg[k].rr_dis;
    end
    sel = pick_ch(lvl_m, dis_m, rrp_ff);
  end

  // ****************************************************************
  // Engine and channel next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_ch = ch_ff;
    nxt_td = td_ff;
    nxt_src = src_ff;
    nxt_dst = dst_ff;
    nxt_rcnt = rcnt_ff;
    nxt_wcnt = wcnt_ff;
    nxt_brd = brd_ff;
    nxt_bwr = bwr_ff;
    nxt_bcnt = bcnt_ff;
    nxt_bq0 = bq0_ff;
    nxt_bq1 = bq1_ff;
    nxt_starve = starve_ff;
    nxt_slot = slot_ff;
    nxt_rrp = rrp_ff;
    nxt_ctd = ctd_ff;
    nxt_cwc = cwc_ff;
    nxt_term0 = 24'h000000;
    nxt_term1 = 24'h000000;
    clr = 24'h000000;
    set = trig_in | cpu_trig;
    qn = 2'h0;
    // Starvation counter while CPU holds a shared spoke
    if ((rd_req && rd_ack) || (wr_req && wr_ack)) begin
      nxt_starve = 8'h00;
    end else if (((rd_want && hit_r) || (wr_bus && hit_w)) && !dma_first) begin
      nxt_starve = starve_ff + 8'h01;
    end
    case (st_ff)
      dph_pkg::ST_ARB: begin
        // Re-arbitrate at every burst boundary
        if (req != 24'h000000) begin
          nxt_ch = sel;
          nxt_rrp = sel;
          nxt_st = dph_pkg::ST_LOAD;
          if (fair_en) begin
            nxt_slot = slot_ff + 7'h01;
          end
        end
      end
      dph_pkg::ST_LOAD: begin
        if (abort || ctd_ff[ch_ff] == dph_pkg::TD_END) begin
          clr[ch_ff] = 1'b1;
          nxt_st = dph_pkg::ST_ARB;
        end else begin
          // Resume from the saved byte count
          nxt_td = pool[ctd_ff[ch_ff]];
          nxt_src = nxt_td.src + (nxt_td.src_inc ? {16'h0000, cwc_ff[ch_ff]} : 32'h0);
          nxt_dst = nxt_td.dst + (nxt_td.dst_inc ? {16'h0000, cwc_ff[ch_ff]} : 32'h0);
          nxt_rcnt = {1'b0, cwc_ff[ch_ff]};
          nxt_wcnt = cwc_ff[ch_ff];
          nxt_brd = 7'h00;
          nxt_bwr = 7'h00;
          nxt_bcnt = 2'h0;
          nxt_st = dph_pkg::ST_RUN;
        end
      end
      dph_pkg::ST_RUN: begin
        // Two-byte queue between read and write sides
        qn = bcnt_ff - {1'b0, wr_fire};
        if (wr_fire) begin
          nxt_bq0 = bq1_ff;
          nxt_dst = td_ff.dst_inc ? dst_ff + 32'h1 : dst_ff;
          nxt_wcnt = wcnt_ff + 16'h0001;
          nxt_bwr = bwr_ff + 7'h01;
        end
        if (rd_fire) begin
          if (qn == 2'h0) begin
            nxt_bq0 = rd_data;
          end else begin
            nxt_bq1 = rd_data;
          end
          nxt_src = td_ff.src_inc ? src_ff + 32'h1 : src_ff;
          nxt_rcnt = rcnt_ff + 17'h00001;
          nxt_brd = brd_ff + 7'h01;
        end
        nxt_bcnt = qn + {1'b0, rd_fire};
        if (abort) begin
          clr[ch_ff] = 1'b1;
          nxt_ctd[ch_ff] = cur.first_td;
          nxt_cwc[ch_ff] = 16'h0000;
          nxt_st = dph_pkg::ST_ARB;
        end else if (last_w) begin
          nxt_cwc[ch_ff] = 16'h0000;
          nxt_term0[ch_ff] = td_ff.irq0;
          if (td_ff.next_td == dph_pkg::TD_END) begin
            // Chain end: rewind and fire linked channels
            clr[ch_ff] = 1'b1;
            nxt_ctd[ch_ff] = cur.first_td;
            nxt_term1[ch_ff] = td_ff.irq1;
            for (int k = 0; k < dph_pkg::NCH; k++) begin
              if (chan_cfg[k].chain_src == ch_ff) begin
                set[k] = 1'b1;
              end
            end
          end else begin
            nxt_ctd[ch_ff] = td_ff.next_td;
            clr[ch_ff] = !td_ff.auto_next;
          end
          nxt_st = dph_pkg::ST_ARB;
        end else if (nxt_bcnt == 2'h0 && (nxt_bwr >= cur.burst || stall_req[ch_ff])) begin
          nxt_cwc[ch_ff] = nxt_wcnt;
          nxt_st = dph_pkg::ST_ARB;
        end
      end
      default: begin
        nxt_st = dph_pkg::ST_ARB;
      end
    endcase
    // Triggers win over a completion clear
    nxt_pend = (pend_ff & ~clr) | set;
    for (int k = 0; k < dph_pkg::NCH; k++) begin
      if (!chan_cfg[k].en || cancel_req[k]) begin
        nxt_pend[k] = 1'b0;
        nxt_ctd[k] = chan_cfg[k].first_td;
        nxt_cwc[k] = 16'h0000;
      end
    end
  end

  // Register engine and channel state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff <= dph_pkg::ST_ARB;
      ch_ff <= 5'h00;
      td_ff <= '0;
      src_ff <= 32'h0;
      dst_ff <= 32'h0;
      rcnt_ff <= 17'h00000;
      wcnt_ff <= 16'h0000;
      brd_ff <= 7'h00;
      bwr_ff <= 7'h00;
      bcnt_ff <= 2'h0;
      bq0_ff <= 8'h00;
      bq1_ff <= 8'h00;
      starve_ff <= 8'h00;
      slot_ff <= 7'h01;
      rrp_ff <= 5'h17;
      pend_ff <= 24'h000000;
      term0_ff <= 24'h000000;
      term1_ff <= 24'h000000;
      for (int k = 0; k < dph_pkg::NCH; k++) begin
        ctd_ff[k] <= dph_pkg::TD_END;
        cwc_ff[k] <= 16'h0000;
      end
    end else begin
      st_ff <= nxt_st;
      ch_ff <= nxt_ch;
      td_ff <= nxt_td;
      src_ff <= nxt_src;
      dst_ff <= nxt_dst;
      rcnt_ff <= nxt_rcnt;
      wcnt_ff <= nxt_wcnt;
      brd_ff <= nxt_brd;
      bwr_ff <= nxt_bwr;
      bcnt_ff <= nxt_bcnt;
      bq0_ff <= nxt_bq0;
      bq1_ff <= nxt_bq1;
      starve_ff <= nxt_starve;
      slot_ff <= nxt_slot;
      rrp_ff <= nxt_rrp;
      pend_ff <= nxt_pend;
      term0_ff <= nxt_term0;
      term1_ff <= nxt_term1;
      ctd_ff <= nxt_ctd;
      cwc_ff <= nxt_cwc;
    end
  end

  // ****************************************************************
  // Descriptor pool
  // ****************************************************************
  // CPU byte writes take precedence over DMA descriptor writes
  always_ff @(posedge clk_sys) begin
    if (cfg_wr && cfg_addr[10:4] != dph_pkg::TD_END) begin
      pool[cfg_addr[10:4]][cfg_addr[3:0]*8 +: 8] <= cfg_data;
    end else if (dwr && dst_ff[10:4] != dph_pkg::TD_END) begin
      pool[dst_ff[10:4]][dst_ff[3:0]*8 +: 8] <= bq0_ff;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rd_addr = src_ff;
  assign wr_addr = dst_ff;
  assign wr_data = bq0_ff;
  assign term0 = term0_ff;
  assign term1 = term1_ff;
  assign busy = st_ff != dph_pkg::ST_ARB;
  assign act_ch = ch_ff;

endmodule

// ### tb/dph_hub_asserts.sv
// Port checks for the DMA hub.
// Assumes one clock domain; bound onto every dph_hub.
`timescale 1ns/100ps
module dph_hub_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control and CPU master
  input wire logic [dph_pkg::NCH-1:0] cancel_req,
  input wire logic cpu_req,
  input wire logic [dph_pkg::SPOKE_W-1:0] cpu_spoke,
  input wire logic cpu_gnt,
  // Spoke ports and status
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  input wire logic rd_ack,
  input wire logic wr_req,
  input wire logic [31:0] wr_addr,
  input wire logic wr_ack,
  input wire logic [dph_pkg::NCH-1:0] term0,
  input wire logic [dph_pkg::NCH-1:0] term1,
  input wire logic busy,
  input wire logic [4:0] act_ch
);
  // *********
  // Checks
  // *********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_GNT_NEEDS_REQ: assert property (cpu_gnt |-> cpu_req)
    else $error("cpu grant without request");
  AST_GNT_WAIT_DMA: assert property (cpu_req && !cpu_gnt |-> busy)
    else $error("cpu held off with dma idle");
  AST_SPOKE_EXCL: assert property (cpu_gnt |-> !(rd_req && rd_addr[18:16] == cpu_spoke)
    && !(wr_req && wr_addr[18:16] == cpu_spoke)) else $error("spoke shared with cpu");
  AST_RD_HOLD: assert property (rd_req && !rd_ack ##1 rd_req && !(|cancel_req)
    |-> $stable(rd_addr)) else $error("read address moved while waiting");
  AST_TERM_PULSE: assert property (|term0 |=> !(|term0))
    else $error("completion pulse too long");
  // Final write lands on a spoke, or in the pool where wr_req stays low
  AST_TERM_CAUSE: assert property (|term0 || |term1 |-> $past((wr_req && wr_ack) ||
    (busy && !wr_req && wr_addr[31:dph_pkg::DESC_LSB] == dph_pkg::DESC_TAG)))
    else $error("completion without final write");
  AST_CANCEL_STOP: assert property (busy && cancel_req[act_ch] |=> !rd_req && !wr_req)
    else $error("request kept after cancel");
  AST_REQ_BUSY: assert property (rd_req || wr_req |-> busy)
    else $error("request while idle");
  // Main scenarios reached
  cover property (rd_req && wr_req);
  cover property (cpu_req && !cpu_gnt);
  cover property (|term1);
endmodule
bind dph_hub dph_hub_asserts i_dph_hub_asserts (.clk_sys, .reset, .cancel_req, .cpu_req,
  .cpu_spoke, .cpu_gnt, .rd_req, .rd_addr, .rd_ack, .wr_req, .wr_addr, .wr_ack, .term0,
  .term1, .busy, .act_ch);

// ### tb/dph_mem_model.sv
// Spoke slave model: byte pattern source and logged sink.
// Assumes requests held until acked; lat sets wait cycles.
`timescale 1ns/100ps
module dph_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Wait cycles before each ack
  input wire logic [3:0] lat,
  // Read port
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  output logic rd_ack,
  output logic [7:0] rd_data,
  // Write port
  input wire logic wr_req,
  input wire logic [31:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic wr_ack
);
  logic [3:0] rcnt;
  logic [3:0] wcnt;
  logic [7:0] last;
  logic [39:0] wlog [$];
  // Data is address based; idle bus shows inverse of last byte
  assign rd_data = rd_ack ? (rd_addr[7:0] ^ 8'ha5) : ~last;
  // Independent acks on both ports, log of accepted writes
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_ack <= 1'b0;
      wr_ack <= 1'b0;
      rcnt <= 4'h0;
      wcnt <= 4'h0;
      last <= 8'h00;
    end else begin
      rd_ack <= rd_req && !rd_ack && rcnt >= lat;
      wr_ack <= wr_req && !wr_ack && wcnt >= lat;
      rcnt <= (rd_req && !rd_ack) ? rcnt + 4'h1 : 4'h0;
      wcnt <= (wr_req && !wr_ack) ? wcnt + 4'h1 : 4'h0;
      if (rd_req && rd_ack) last <= rd_data;
      if (wr_req && wr_ack) wlog.push_back({wr_addr, wr_data});
    end
  end
endmodule

// ### tb/dph_hub_tb_top.sv
// Self-checking bench for the DMA hub.
// Assumes the checker is bound and the slave model logs writes.
`timescale 1ns/100ps
module dph_hub_tb_top;
  logic clk_sys, reset, fair_en, cfg_wr, cpu_req, cpu_gnt, rd_req, rd_ack, wr_req, wr_ack, busy;
  logic [23:0] trig_in, cpu_trig, stall_req, cancel_req, term0, term1;
  logic [10:0] cfg_addr;
  logic [7:0] cfg_data, rd_data, wr_data;
  logic [2:0] cpu_spoke;
  logic [31:0] rd_addr, wr_addr;
  logic [4:0] act_ch;
  logic [3:0] lat;
  dph_pkg::dph_ch_cfg_t chan_cfg [dph_pkg::NCH];
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  dph_hub i_dph_hub (.clk_sys, .reset, .chan_cfg, .fair_en, .trig_in, .cpu_trig, .stall_req,
    .cancel_req, .cfg_wr, .cfg_addr, .cfg_data, .cpu_req, .cpu_spoke, .cpu_gnt, .rd_req,
    .rd_addr, .rd_ack, .rd_data, .wr_req, .wr_addr, .wr_data, .wr_ack, .term0, .term1,
    .busy, .act_ch);
  dph_mem_model i_dph_mem_model (.clk_sys, .reset, .lat, .rd_req, .rd_addr, .rd_ack,
    .rd_data, .wr_req, .wr_addr, .wr_data, .wr_ack);
  // *********
  // Tasks
  // *********
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  function automatic dph_pkg::dph_td_t mk(input logic [31:0] s, d, input logic [15:0] n,
    input logic [6:0] nx, input logic [5:0] fl);
    return dph_pkg::dph_td_t'({35'h0, fl, nx, n, d, s});
  endfunction
  task automatic put_td(input logic [6:0] idx, input dph_pkg::dph_td_t td);
    for (int b = 0; b < 16; b++) begin
      @(posedge clk_sys);
      cfg_wr <= 1'b1;
      cfg_addr <= {idx, 4'(b)};
      cfg_data <= td[8*b+:8];
    end
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task automatic setch(input int c, input logic [2:0] p, input logic rr, input logic [4:0] cs,
    input logic [6:0] ft);
    @(posedge clk_sys);
    chan_cfg[c] <= '{1'b0, p, rr, 7'h02, cs, ft};
    @(posedge clk_sys);
    chan_cfg[c].en <= 1'b1;
  endtask
  task automatic pulse(input logic [23:0] t, input logic cpu);
    @(posedge clk_sys);
    cpu_trig <= cpu ? t : 24'h0;
    trig_in <= cpu ? 24'h0 : t;
    @(posedge clk_sys);
    cpu_trig <= 24'h0;
    trig_in <= 24'h0;
  endtask
  task automatic wt(input int c, input logic t1);
    int n;
    n = 0;
    while (term0[c] !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    chk(term0[c] === 1'b1 && term1[c] === t1, "completion pulse");
    @(posedge clk_sys);
  endtask
  task automatic chkw(input int o, n, input logic [31:0] d, s);
    for (int i = 0; i < n; i++) begin
      chk(i_dph_mem_model.wlog[o+i] === {d + 32'(i), (s[7:0] + 8'(i)) ^ 8'ha5}, "write");
    end
  endtask
  task automatic logsz(input int n);
    chk(i_dph_mem_model.wlog.size() == n, "write count");
    i_dph_mem_model.wlog.delete();
  endtask
  task automatic race(input int a, b, w);
    int n;
    n = 0;
    pulse((24'h1 << a) | (24'h1 << b), 1'b0);
    while (term0 === 24'h0 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk(term0 === (24'h1 << w), "grant order");
    wt(a + b - w, 1'b1);
  endtask
  task automatic stop(input logic [23:0] m);
    cancel_req <= m;
    repeat (4) @(posedge clk_sys);
    chk(busy === 1'b0 && rd_req === 1'b0 && term0 === 24'h0, "cancel");
    cancel_req <= 24'h0;
  endtask
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      end_sim();
    end
  end
  // *********
  // Scenarios
  // *********
  initial begin
    {reset, fair_en, cfg_wr, cpu_req, cpu_spoke, lat, cfg_addr, cfg_data} = '0;
    {trig_in, cpu_trig, stall_req, cancel_req} = '0;
    for (int c = 0; c < 24; c++) chan_cfg[c] = '{1'b0, 3'h7, 1'b0, 7'h02, 5'h1f, 7'h00};
    reset = 1'b1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    put_td(7'h00, mk(32'h0001_0010, 32'h100, 16'h3, 7'h7f, 6'h1e));
    setch(3, 3'h2, 1'b0, 5'h1f, 7'h00);
    cpu_req <= 1'b1;
    pulse(24'h000008, 1'b0);
    repeat (8) @(posedge clk_sys);
    chk(cpu_gnt === 1'b1 && busy === 1'b1 && wr_req === 1'b0, "cpu first");
    wt(3, 1'b1);
    cpu_req <= 1'b0;
    chkw(0, 4, 32'h100, 32'h0001_0010);
    logsz(4);
    put_td(7'h01, mk(32'h0001_0020, 32'h110, 16'h1, 7'h02, 6'h2e));
    put_td(7'h02, mk(32'h0001_0030, 32'h120, 16'h1, 7'h7f, 6'h1e));
    put_td(7'h03, mk(32'h0001_0040, 32'h130, 16'h0, 7'h7f, 6'h1e));
    setch(5, 3'h2, 1'b0, 5'h1f, 7'h01);
    setch(6, 3'h2, 1'b0, 5'h05, 7'h03);
    pulse(24'h000020, 1'b1);
    wt(5, 1'b0);
    wt(5, 1'b1);
    wt(6, 1'b1);
    chkw(0, 2, 32'h110, 32'h0001_0020);
    chkw(2, 2, 32'h120, 32'h0001_0030);
    chkw(4, 1, 32'h130, 32'h0001_0040);
    logsz(5);
    put_td(7'h04, mk(32'h0001_0050, 32'h140, 16'h0, 7'h7f, 6'h1e));
    setch(8, 3'h2, 1'b0, 5'h1f, 7'h04);
    setch(9, 3'h1, 1'b0, 5'h1f, 7'h04);
    setch(10, 3'h3, 1'b0, 5'h1f, 7'h04);
    setch(11, 3'h3, 1'b1, 5'h1f, 7'h04);
    fair_en <= 1'b1;
    race(8, 9, 9);
    fair_en <= 1'b0;
    race(8, 9, 9);
    race(10, 11, 11);
    logsz(6);
    put_td(7'h05, mk(32'h0001_0000, 32'h300, 16'h0, 7'h7f, 6'h0f));
    setch(12, 3'h0, 1'b0, 5'h1f, 7'h05);
    lat <= 4'h6;
    pulse(24'h001000, 1'b0);
    repeat (40) @(posedge clk_sys);
    chk(busy === 1'b1 && act_ch === 5'h0c && term0 === 24'h0, "endless run");
    stall_req <= 24'h001000;
    repeat (30) @(posedge clk_sys);
    chk(busy === 1'b0 && rd_req === 1'b0 && wr_req === 1'b0, "stall");
    stall_req <= 24'h0;
    repeat (4) @(posedge clk_sys);
    chk(busy === 1'b1 && act_ch === 5'h0c, "resume");
    stop(24'h001000);
    lat <= 4'h0;
    i_dph_mem_model.wlog.delete();
    put_td(7'h06, mk(32'h0001_0060, 32'h150, 16'h0, 7'h06, 6'h2e));
    setch(13, 3'h2, 1'b0, 5'h1f, 7'h06);
    pulse(24'h002000, 1'b0);
    repeat (3) wt(13, 1'b0);
    stop(24'h002000);
    for (int i = 0; i < 3; i++) chkw(i, 1, 32'h150, 32'h0001_0060);
    i_dph_mem_model.wlog.delete();
    put_td(7'h07, mk(32'h0001_00a5, 32'h0002_0080, 16'h3, 7'h08, 6'h26));
    put_td(7'h08, mk(32'h0, 32'h200, 16'h3, 7'h7f, 6'h1e));
    setch(14, 3'h2, 1'b0, 5'h1f, 7'h07);
    pulse(24'h004000, 1'b1);
    wt(14, 1'b1);
    chkw(0, 4, 32'h200, 32'h0d02_0300);
    logsz(4);
    end_sim();
  end
endmodule
